// ===== pkg/irq2_pkg.sv
`default_nettype none

package irq2_pkg;

    // ========================================
    // register location and reset
    localparam logic [7:0] secondary_addr    = 8'ha9;
    localparam logic [7:0] primary_addr      = 8'ha8;
    localparam logic [7:0] secondary_reset   = 8'ha0;

    // ========================================
    // bit positions
    localparam int unsigned bit_reserved     = 7;
    localparam int unsigned bit_timer_prio   = 6;
    localparam int unsigned bit_supply_prio  = 5;
    localparam int unsigned bit_serial_prio  = 4;
    localparam int unsigned bit_must_zero    = 3;
    localparam int unsigned bit_timer_en     = 2;
    localparam int unsigned bit_supply_en    = 1;
    localparam int unsigned bit_serial_en    = 0;
    localparam int unsigned bit_global_en    = 7;

    // ========================================
    // source count and priority levels
    localparam int unsigned num_sources      = 3;

    typedef enum logic {
        prio_low,
        prio_high
    } prio_level_t;

endpackage : irq2_pkg

`default_nettype wire

// ===== verilog/irq_source_gate.sv
`timescale 1ns/10ps
`default_nettype none

module irq_source_gate
    import irq2_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // controls
    input  wire logic        source_enable,
    input  wire logic        global_enable,
    input  wire logic        priority_sel,
    // event
    input  wire logic        source_request,
    // to core
    output logic             request_q,
    output irq2_pkg::prio_level_t level_q
);

    // ========================================
    // gated request with priority tag
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            request_q <= 1'b0;
        end else begin
            request_q <= source_request & source_enable & global_enable;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level_q <= prio_low;
        end else begin
            level_q <= priority_sel ? prio_high : prio_low;
        end
    end

endmodule : irq_source_gate

`default_nettype wire

// ===== verilog/secondary_irq_enable_priority.sv
`timescale 1ns/10ps
`default_nettype none

module secondary_irq_enable_priority
    import irq2_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // special function register bus
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_write,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    output logic             sfr_hit,
    // global enable from primary enable register
    input  wire logic        global_irq_enable,
    // source events
    input  wire logic        interval_timer_event,
    input  wire logic        supply_monitor_event,
    input  wire logic        serial_port_event,
    // requests to core
    output logic [2:0]       irq_request,
    output logic [2:0]       irq_high_priority
);

    // ========================================
    // local constants
    localparam logic [7:0]  idle_rdata = 8'h00;
    localparam int unsigned src_timer  = 0;
    localparam int unsigned src_supply = 1;
    localparam int unsigned src_serial = 2;

    // ========================================
    // bus decode
    logic sel;
    logic write_hit;

    // hit is combinational so the core sees it in the address cycle
    assign sel       = (sfr_addr == secondary_addr);
    assign sfr_hit   = sel;
    assign write_hit = sfr_write & sel;

    // ========================================
    // priority selects
    logic interval_timer_priority_q;
    logic interval_timer_priority_d;
    logic supply_monitor_priority_q;
    logic supply_monitor_priority_d;
    logic serial_port_priority_q;
    logic serial_port_priority_d;

    always_comb begin
        interval_timer_priority_d = interval_timer_priority_q;
        supply_monitor_priority_d = supply_monitor_priority_q;
        serial_port_priority_d    = serial_port_priority_q;
        if (write_hit) begin
            interval_timer_priority_d = sfr_wdata[bit_timer_prio];
            supply_monitor_priority_d = sfr_wdata[bit_supply_prio];
            serial_port_priority_d    = sfr_wdata[bit_serial_prio];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            interval_timer_priority_q <= secondary_reset[bit_timer_prio];
            supply_monitor_priority_q <= secondary_reset[bit_supply_prio];
            serial_port_priority_q    <= secondary_reset[bit_serial_prio];
        end else begin
            interval_timer_priority_q <= interval_timer_priority_d;
            supply_monitor_priority_q <= supply_monitor_priority_d;
            serial_port_priority_q    <= serial_port_priority_d;
        end
    end

    // ========================================
    // source enables
    logic interval_timer_irq_enable_q;
    logic interval_timer_irq_enable_d;
    logic supply_monitor_irq_enable_q;
    logic supply_monitor_irq_enable_d;
    logic serial_port_irq_enable_q;
    logic serial_port_irq_enable_d;

    // only a software write moves an enable; events never touch them
    always_comb begin
        interval_timer_irq_enable_d = interval_timer_irq_enable_q;
        supply_monitor_irq_enable_d = supply_monitor_irq_enable_q;
        serial_port_irq_enable_d    = serial_port_irq_enable_q;
        if (write_hit) begin
            interval_timer_irq_enable_d = sfr_wdata[bit_timer_en];
            supply_monitor_irq_enable_d = sfr_wdata[bit_supply_en];
            serial_port_irq_enable_d    = sfr_wdata[bit_serial_en];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            interval_timer_irq_enable_q <= secondary_reset[bit_timer_en];
            supply_monitor_irq_enable_q <= secondary_reset[bit_supply_en];
            serial_port_irq_enable_q    <= secondary_reset[bit_serial_en];
        end else begin
            interval_timer_irq_enable_q <= interval_timer_irq_enable_d;
            supply_monitor_irq_enable_q <= supply_monitor_irq_enable_d;
            serial_port_irq_enable_q    <= serial_port_irq_enable_d;
        end
    end

    // ========================================
    // reserved and must-be-zero bits
    logic reserved_bit_q;
    logic reserved_bit_d;
    logic must_zero_bit_q;
    logic must_zero_bit_d;

    // kept as written so a read returns what software stored;
    // neither bit reaches the request gating
    always_comb begin
        reserved_bit_d  = reserved_bit_q;
        must_zero_bit_d = must_zero_bit_q;
        if (write_hit) begin
            reserved_bit_d  = sfr_wdata[bit_reserved];
            must_zero_bit_d = sfr_wdata[bit_must_zero];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reserved_bit_q  <= secondary_reset[bit_reserved];
            must_zero_bit_q <= secondary_reset[bit_must_zero];
        end else begin
            reserved_bit_q  <= reserved_bit_d;
            must_zero_bit_q <= must_zero_bit_d;
        end
    end

    // ========================================
    // register image for read back
    logic [7:0] register_word;

    always_comb begin
        register_word                  = idle_rdata;
        register_word[bit_reserved]    = reserved_bit_q;
        register_word[bit_timer_prio]  = interval_timer_priority_q;
        register_word[bit_supply_prio] = supply_monitor_priority_q;
        register_word[bit_serial_prio] = serial_port_priority_q;
        register_word[bit_must_zero]   = must_zero_bit_q;
        register_word[bit_timer_en]    = interval_timer_irq_enable_q;
        register_word[bit_supply_en]   = supply_monitor_irq_enable_q;
        register_word[bit_serial_en]   = serial_port_irq_enable_q;
    end

    // ========================================
    // registered read data
    logic [7:0] sfr_rdata_d;

    // off-address reads return zero so the core can or read buses together
    always_comb begin
        sfr_rdata_d = idle_rdata;
        if (sel) begin
            sfr_rdata_d = register_word;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= idle_rdata;
        end else begin
            sfr_rdata <= sfr_rdata_d;
        end
    end

    // ========================================
    // per-source vectors
    logic [2:0] enables;
    logic [2:0] priorities;
    logic [2:0] events;

    assign enables[src_timer]    = interval_timer_irq_enable_q;
    assign enables[src_supply]   = supply_monitor_irq_enable_q;
    assign enables[src_serial]   = serial_port_irq_enable_q;
    assign priorities[src_timer] = interval_timer_priority_q;
    assign priorities[src_supply] = supply_monitor_priority_q;
    assign priorities[src_serial] = serial_port_priority_q;
    assign events[src_timer]     = interval_timer_event;
    assign events[src_supply]    = supply_monitor_event;
    assign events[src_serial]    = serial_port_event;

    // ========================================
    // per-source gating
    prio_level_t levels [num_sources];

    genvar g;
    generate
        for (g = 0; g < num_sources; g++) begin : gen_src
            irq_source_gate u_gate (
                .clock          (clock),
                .reset_n        (reset_n),
                .source_enable  (enables[g]),
                .global_enable  (global_irq_enable),
                .priority_sel   (priorities[g]),
                .source_request (events[g]),
                .request_q      (irq_request[g]),
                .level_q        (levels[g])
            );
            assign irq_high_priority[g] = (levels[g] == prio_high);
        end
    endgenerate

endmodule : secondary_irq_enable_priority

`default_nettype wire

// ===== bench/irq2_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module irq2_chk
    import irq2_pkg::*;
(
    // clock and reset
    input wire logic       clock,
    input wire logic       reset_n,
    // register bus
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_write,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_hit,
    // sources and requests
    input wire logic       global_irq_enable,
    input wire logic       interval_timer_event,
    input wire logic       supply_monitor_event,
    input wire logic       serial_port_event,
    input wire logic [2:0] irq_request,
    input wire logic [2:0] irq_high_priority
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    chk_hit_decode: assert property (sfr_hit == (sfr_addr == secondary_addr)) else $error("hit");
    chk_idle_read: assert property (!sfr_hit |=> sfr_rdata == 8'h00) else $error("idle read");
    chk_write_back: assert property (sfr_write && sfr_hit ##1 sfr_hit |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("readback");
    chk_prio_map: assert property (sfr_hit |=> irq_high_priority == {sfr_rdata[4], sfr_rdata[5], sfr_rdata[6]})
        else $error("prio");
    chk_enable_map: assert property (sfr_hit && global_irq_enable && interval_timer_event && supply_monitor_event
        && serial_port_event |=> irq_request == {sfr_rdata[0], sfr_rdata[1], sfr_rdata[2]}) else $error("enable");
    chk_global_off: assert property (!global_irq_enable |=> irq_request == 3'h0) else $error("global");
    chk_timer_gate: assert property (!interval_timer_event |=> !irq_request[0]) else $error("timer");
    chk_reset_prio: assert property ($rose(reset_n) |=> irq_high_priority == 3'h2) else $error("reset");
    cover property (irq_request == 3'h7);
    cover property (sfr_write && !sfr_hit);
    cover property ($rose(reset_n));
endmodule : irq2_chk
bind secondary_irq_enable_priority irq2_chk u_irq2_chk (.clock, .reset_n, .sfr_write, .sfr_hit, .global_irq_enable,
    .interval_timer_event, .supply_monitor_event, .serial_port_event, .sfr_addr, .sfr_wdata, .sfr_rdata,
    .irq_request, .irq_high_priority);
`default_nettype wire

// ===== bench/core_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input  wire logic       clock,
    output logic [7:0]      sfr_addr = 8'ha9,
    output logic            sfr_write = 1'b0,
    output logic [7:0]      sfr_wdata = 8'h00,
    output logic            global_irq_enable = 1'b0
);
    // one write, data inverted once no longer held
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic g);
        @(posedge clock);
        sfr_addr <= a;
        sfr_write <= 1'b1;
        sfr_wdata <= d & 8'hf7;
        global_irq_enable <= g;
        @(posedge clock);
        sfr_write <= 1'b0;
        sfr_wdata <= ~d;
        sfr_addr <= 8'ha9;
    endtask : wr
endmodule : core_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import irq2_pkg::*;
    typedef struct packed {logic [7:0] w; logic g; logic [2:0] ev, req, prio;} row_t;
    row_t rows [7] = '{'{8'h77, 1'b1, 3'h7, 3'h7, 3'h7}, '{8'h77, 1'b0, 3'h7, 3'h0, 3'h7},
        '{8'h44, 1'b1, 3'h7, 3'h1, 3'h1}, '{8'h22, 1'b1, 3'h7, 3'h2, 3'h2}, '{8'h11, 1'b1, 3'h7, 3'h4, 3'h4},
        '{8'h07, 1'b1, 3'h2, 3'h2, 3'h0}, '{8'h80, 1'b1, 3'h7, 3'h0, 3'h0}};
    logic clock = 1'b0, reset_n = 1'b0, sfr_write, sfr_hit, global_irq_enable;
    logic [2:0] ev = 3'h0, irq_request, irq_high_priority;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    int num_errors = 0, n_tests = 0;
    always #12.5 clock = ~clock;
    secondary_irq_enable_priority u_secondary_irq_enable_priority (.clock, .reset_n, .sfr_addr, .sfr_write,
        .sfr_wdata, .sfr_rdata, .sfr_hit, .global_irq_enable, .interval_timer_event(ev[0]),
        .supply_monitor_event(ev[1]), .serial_port_event(ev[2]), .irq_request, .irq_high_priority);
    core_model u_core_model (.clock, .sfr_addr, .sfr_write, .sfr_wdata, .global_irq_enable);
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic do_reset;
        reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check(sfr_rdata, 8'ha0);
        check({5'h0, irq_high_priority}, 8'h02);
        $display("test reset done");
    endtask : do_reset
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        do_reset();
        foreach (rows[i]) begin
            u_core_model.wr(8'ha9, rows[i].w, rows[i].g);
            ev <= rows[i].ev;
            @(posedge clock);
            #1;
            check({5'h0, irq_request}, {5'h0, rows[i].req});
            check({5'h0, irq_high_priority}, {5'h0, rows[i].prio});
            check(sfr_rdata, rows[i].w);
        end
        $display("test rows done");
        fork
            u_core_model.wr(8'ha8, 8'hff, 1'b1);
            begin
                @(posedge clock);
                #1;
                check({7'h0, sfr_hit}, 8'h00);
            end
        join
        #1;
        check(sfr_rdata, 8'h00);
        @(posedge clock);
        #1;
        check(sfr_rdata, 8'h80);
        check({7'h0, sfr_hit}, 8'h01);
        $display("test unmapped done");
        do_reset();
        report_and_stop();
    end
    initial begin
        repeat (1000) @(posedge clock);
        num_errors++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
